// file: cscu_cfg.svh
// Constants of the clock source control unit: offsets, fields, resets, timing.
// Assumes inclusion by bare name from every design file that needs them.
//
// Overview of operation
// - System clock comes from crystal, fast RC, slow RC or synthesiser output.
// - Watchdog timer always runs from the slow RC oscillator.
// - Crystal failure forces the system clock over to the fast RC oscillator.
// - Software crystal enable bit turns the crystal oscillator on and off.
// - Crystal clock stays withheld from users until crystal ready is set.
// - Crystal becoming stable raises clock ready interrupt when its enable is set.
// - After reset the fast 8 MHz RC oscillator is the system clock.
// - Fast RC enable bit switches it; its stability shows in fast RC ready.
// - Fast RC becoming stable raises clock ready interrupt when enabled.
// - Synthesiser reference is either the fast RC or the crystal clock.
// - With wakeup RC enable set, wakeup from crystal or synthesiser runs the system from fast RC.
// - After wakeup the original source returns once its ready flag is set.
// - Synthesiser output is input times feedback value over output value.
// - Output divider code 00..11 gives divide by 1, 2, 4, 8.
// - Feedback code 0000 selects 16, other codes their own value.
// - Synthesiser enable bit, ready flag on lock, interrupt when enabled.
// - Slow RC always on, ready flag when stable, interrupt when enabled.
// - On a selection change the old clock runs until the new is ready.
// - Crystal failure disables crystal, sets stuck flag, optional NMI.
// - Crystal failure also stops synthesiser running from crystal as system clock.
`ifndef CSCU_CFG_SVH
`define CSCU_CFG_SVH

// Timing
`define CSCU_CLK_NS          8
`define CSCU_XTAL_START_NS   4000
`define CSCU_FAST_START_NS   800
`define CSCU_SLOW_START_NS   1600
`define CSCU_SYNTH_LOCK_NS   2000
`define CSCU_CYC(t)          (((t) + `CSCU_CLK_NS - 1) / `CSCU_CLK_NS)

// Register offsets (byte addresses)
`define CSCU_OFS_CFG         12'h000
`define CSCU_OFS_CTL         12'h004
`define CSCU_OFS_STAT        12'h008
`define CSCU_OFS_INT         12'h00C
`define CSCU_OFS_SYNTH       12'h018
`define CSCU_OFS_SRC         12'h034

// Reset values and writable masks
`define CSCU_CFG_RST         32'h0000_0100
`define CSCU_CFG_MASK        32'h0000_0100
`define CSCU_CTL_RST         32'h0000_0803
`define CSCU_CTL_MASK        32'h0003_0E07
`define CSCU_INT_EN_MASK     32'h003D_0000
`define CSCU_SYNTH_MASK      32'h0000_003F
`define CSCU_ZERO            32'h0000_0000

// Field positions
`define CSCU_B_REF_FAST      8
`define CSCU_B_WAKE_RC       17
`define CSCU_B_MON           16
`define CSCU_B_FAST          11
`define CSCU_B_XTAL          10
`define CSCU_B_SYNTH         9
`define CSCU_SW_MSB          2
`define CSCU_B_ST_SYNTH      1
`define CSCU_B_ST_XTAL       2
`define CSCU_B_ST_FAST       3
`define CSCU_B_ST_SLOW       5
`define CSCU_B_STUCK         0
`define CSCU_B_RDY_LSB       2
`define CSCU_B_STUCK_IE      16
`define CSCU_B_IE_LSB        18
`define CSCU_FB_MSB          3
`define CSCU_OD_LSB          4
`define CSCU_OD_MSB          5

// Source codes
`define CSCU_SRC_SYNTH       3'h1
`define CSCU_SRC_XTAL        3'h2
`define CSCU_SRC_FAST        3'h3
`define CSCU_SRC_SLOW        3'h7

// Source index in ready vectors
`define CSCU_I_SYNTH         0
`define CSCU_I_XTAL          1
`define CSCU_I_FAST          2
`define CSCU_I_SLOW          3
`define CSCU_NSRC            4

// Divider decode constants
`define CSCU_FB_ZERO         4'h0
`define CSCU_FB_SIXTEEN      5'h10
`define CSCU_OD_ONE          4'h1

`endif

// file: cscu_pkg.sv
// Types shared by the clock source control unit.
// Assumes nothing beyond the constants header.
package cscu_pkg;
    typedef logic [2:0]  cscu_src_type;
    typedef logic [11:0] cscu_cnt_type;
    typedef enum logic [0:0] {
        CSCU_RUN,
        CSCU_WAKE
    } cscu_mode_type;
endpackage

// file: cscu_ready_timer.sv
// Start-up or lock delay of one clock source, giving its ready flag.
// Assumes enable comes from logic on the same clock.
`timescale 1ns/1ps
`include "cscu_cfg.svh"
module cscu_ready_timer
    import cscu_pkg::*;
#(
    parameter cscu_cnt_type START = 12'h001
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // Source control
    input  wire logic enable,
    output logic      ready
);
    cscu_cnt_type cnt;
    wire          done = (cnt == START - 12'h001);

    // Drops at once when disabled, full delay again after
    always_ff @(posedge clk) begin
        if (!nrst || !enable) begin
            cnt   <= 12'h000;
            ready <= 1'b0;
        end else if (!ready) begin
            cnt   <= done ? cnt : cnt + 12'h001;
            ready <= done;
        end
    end
endmodule

// file: cscu_div_decode.sv
// Decode of the synthesiser divider setup codes into divider values.
// Assumes the codes come from registers on the same clock.
`timescale 1ns/1ps
`include "cscu_cfg.svh"
module cscu_div_decode (
    // Setup codes
    input  wire logic [3:0] fb_code,
    input  wire logic [1:0] od_code,
    // Divider values
    output logic      [4:0] fb_value,
    output logic      [3:0] od_value
);
    // Output value = input * fb_value / od_value
    assign fb_value = (fb_code == `CSCU_FB_ZERO) ? `CSCU_FB_SIXTEEN : {1'b0, fb_code};
    assign od_value = `CSCU_OD_ONE << od_code;
endmodule

// file: cscu_top.sv
// Clock source control unit: enables, ready flags, system clock switch,
// crystal failure handling, divider decode and Wishbone register file.
// Assumes a classic Wishbone master on clk; crystal_fail comes from an
// asynchronous monitor; wake_req is a one-cycle pulse on clk.
`timescale 1ns/1ps
`include "cscu_cfg.svh"
module cscu_top
    import cscu_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Events from outside
    input  wire logic        crystal_fail,
    input  wire logic        wake_req,
    // Oscillator controls
    output logic             crystal_osc_en,
    output logic             fast_rc_osc_en,
    output logic             slow_rc_osc_en,
    output logic             synth_en,
    output logic             synth_ref_fast_rc,
    output logic             crystal_clk_release,
    // Clock selections
    output cscu_src_type     system_clock_select,
    output cscu_src_type     wdt_clock_select,
    output logic      [4:0]  feedback_div_value,
    output logic      [3:0]  output_div_value,
    // Interrupts
    output logic             clock_ready_irq,
    output logic             crystal_stuck_nmi
);
    localparam cscu_cnt_type START_CYC [`CSCU_NSRC] = '{
        12'(`CSCU_CYC(`CSCU_SYNTH_LOCK_NS)),
        12'(`CSCU_CYC(`CSCU_XTAL_START_NS)),
        12'(`CSCU_CYC(`CSCU_FAST_START_NS)),
        12'(`CSCU_CYC(`CSCU_SLOW_START_NS))
    };

    // Register state
    logic [31:0]   cfg;
    logic [31:0]   ctl;
    logic [31:0]   int_en;
    logic [31:0]   synth_cfg;
    logic          stuck_flag;
    logic [3:0]    rdy_stat;
    logic [3:0]    rdy_q;
    logic          synth_ref;
    cscu_src_type  cur_src;
    cscu_mode_type mode;
    logic          fail_s1;
    logic          fail_s2;

    // Bus decode
    wire        access   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire        wr       = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i;
    wire [31:0] wmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire        hit_cfg  = ({wb_adr_i[11:2], 2'h0} == `CSCU_OFS_CFG);
    wire        hit_ctl  = ({wb_adr_i[11:2], 2'h0} == `CSCU_OFS_CTL);
    wire        hit_stat = ({wb_adr_i[11:2], 2'h0} == `CSCU_OFS_STAT);
    wire        hit_int  = ({wb_adr_i[11:2], 2'h0} == `CSCU_OFS_INT);
    wire        hit_syn  = ({wb_adr_i[11:2], 2'h0} == `CSCU_OFS_SYNTH);
    wire        hit_src  = ({wb_adr_i[11:2], 2'h0} == `CSCU_OFS_SRC);
    wire [31:0] wclr     = (wr & hit_int) ? (wb_dat_i & wmask) : `CSCU_ZERO;

    // Ready flags from the start-up timers
    wire [3:0] rdy;
    wire [3:0] en_eff;

    // Control fields
    wire          sw_ref   = cfg[`CSCU_B_REF_FAST];
    cscu_src_type sw_sel;
    assign sw_sel = ctl[`CSCU_SW_MSB:0];
    wire          ctl_xtal = ctl[`CSCU_B_XTAL];
    wire          ctl_fast = ctl[`CSCU_B_FAST];
    wire          ctl_syn  = ctl[`CSCU_B_SYNTH];
    wire          ctl_mon  = ctl[`CSCU_B_MON];
    wire          ctl_wake = ctl[`CSCU_B_WAKE_RC];

    // Sources in use cannot be stopped; the switch target is started too
    assign en_eff[`CSCU_I_XTAL]  = ctl_xtal | (ctl_syn & ~synth_ref)
                                 | (cur_src == `CSCU_SRC_XTAL) | (sw_sel == `CSCU_SRC_XTAL);
    assign en_eff[`CSCU_I_FAST]  = ctl_fast | ctl_mon | (ctl_syn & synth_ref)
                                 | (cur_src == `CSCU_SRC_FAST) | (sw_sel == `CSCU_SRC_FAST);
    assign en_eff[`CSCU_I_SYNTH] = ctl_syn | (cur_src == `CSCU_SRC_SYNTH) | (sw_sel == `CSCU_SRC_SYNTH);
    assign en_eff[`CSCU_I_SLOW]  = 1'b1;

    // Synthesiser waits for its reference before the lock delay runs
    wire ref_rdy = synth_ref ? rdy[`CSCU_I_FAST] : rdy[`CSCU_I_XTAL];
    wire [3:0] tmr_en = {en_eff[3:1], en_eff[`CSCU_I_SYNTH] & ref_rdy};

    genvar gi;
    generate
        for (gi = 0; gi < `CSCU_NSRC; gi++) begin : g_src
            cscu_ready_timer #(
                .START (START_CYC[gi])
            ) u_tmr (
                .clk    (clk),
                .nrst   (nrst),
                .enable (tmr_en[gi]),
                .ready  (rdy[gi])
            );
            // Sticky ready status, set wins over clear
            always_ff @(posedge clk) begin
                if (!nrst) begin
                    rdy_q[gi]    <= 1'b0;
                    rdy_stat[gi] <= 1'b0;
                end else begin
                    rdy_q[gi]    <= rdy[gi];
                    rdy_stat[gi] <= (rdy[gi] & ~rdy_q[gi]) | (rdy_stat[gi] & ~wclr[`CSCU_B_RDY_LSB + gi]);
                end
            end
        end
    endgenerate

    // Crystal failure from the monitor
    wire fail_evt = fail_s2 & ctl_mon & en_eff[`CSCU_I_XTAL];
    wire syn_kill = fail_evt & ~synth_ref & (cur_src == `CSCU_SRC_SYNTH);
    wire wake_hit = wake_req & ctl_wake
                  & ((cur_src == `CSCU_SRC_XTAL) | (cur_src == `CSCU_SRC_SYNTH));

    // Readiness of the requested source
    wire tgt_rdy = (sw_sel == `CSCU_SRC_SYNTH) ? rdy[`CSCU_I_SYNTH] :
                   (sw_sel == `CSCU_SRC_XTAL)  ? rdy[`CSCU_I_XTAL]  :
                   (sw_sel == `CSCU_SRC_FAST)  ? rdy[`CSCU_I_FAST]  :
                   (sw_sel == `CSCU_SRC_SLOW)  ? rdy[`CSCU_I_SLOW]  : 1'b0;

    // Register write values
    wire [31:0] ctl_wr   = (wr & hit_ctl) ? (((ctl & ~wmask) | (wb_dat_i & wmask)) & `CSCU_CTL_MASK) : ctl;
    wire [31:0] ctl_kill = (32'h0000_0001 << `CSCU_B_XTAL) | (syn_kill ? (32'h0000_0001 << `CSCU_B_SYNTH) : `CSCU_ZERO)
                         | 32'h0000_0007;
    wire [31:0] next_ctl = fail_evt ? ((ctl_wr & ~ctl_kill) | {29'h0000_0000, `CSCU_SRC_FAST}) : ctl_wr;
    wire [31:0] next_cfg = (wr & hit_cfg) ? (((cfg & ~wmask) | (wb_dat_i & wmask)) & `CSCU_CFG_MASK) : cfg;
    wire [31:0] next_ien = (wr & hit_int) ? (((int_en & ~wmask) | (wb_dat_i & wmask)) & `CSCU_INT_EN_MASK) : int_en;
    wire [31:0] next_syn = (wr & hit_syn) ? (((synth_cfg & ~wmask) | (wb_dat_i & wmask)) & `CSCU_SYNTH_MASK)
                                          : synth_cfg;
    wire        next_stk = fail_evt | (stuck_flag & ~wclr[`CSCU_B_STUCK]);
    // Reference change only takes effect with both candidates ready
    wire        next_ref = (rdy[`CSCU_I_FAST] & rdy[`CSCU_I_XTAL]) ? sw_ref : synth_ref;

    // Source switch sequencing
    cscu_src_type  next_cur;
    cscu_mode_type next_mode;
    always_comb begin
        next_cur  = cur_src;
        next_mode = mode;
        case (mode)
            CSCU_RUN: begin
                if (fail_evt) begin
                    next_cur = `CSCU_SRC_FAST;
                end else if (wake_hit) begin
                    next_cur  = `CSCU_SRC_FAST;
                    next_mode = CSCU_WAKE;
                end else if (sw_sel != cur_src && tgt_rdy) begin
                    next_cur = sw_sel;
                end
            end
            CSCU_WAKE: begin
                if (fail_evt) begin
                    next_cur  = `CSCU_SRC_FAST;
                    next_mode = CSCU_RUN;
                end else if (tgt_rdy) begin
                    next_cur  = sw_sel;
                    next_mode = CSCU_RUN;
                end
            end
            default: begin
                next_cur  = `CSCU_SRC_FAST;
                next_mode = CSCU_RUN;
            end
        endcase
    end

    // Divider decode
    wire [4:0] fb_val;
    wire [3:0] od_val;
    cscu_div_decode u_div (
        .fb_code  (synth_cfg[`CSCU_FB_MSB:0]),
        .od_code  (synth_cfg[`CSCU_OD_MSB:`CSCU_OD_LSB]),
        .fb_value (fb_val),
        .od_value (od_val)
    );

    // Read data
    wire [31:0] stat_word = {26'h000_0000, rdy[`CSCU_I_SLOW], 1'b0, rdy[`CSCU_I_FAST],
                             rdy[`CSCU_I_XTAL], rdy[`CSCU_I_SYNTH], 1'b0};
    wire [31:0] int_word  = int_en | {26'h000_0000, rdy_stat, 1'b0, stuck_flag};
    wire [31:0] rd_word   = hit_cfg  ? cfg :
                            hit_ctl  ? ctl :
                            hit_stat ? stat_word :
                            hit_int  ? int_word :
                            hit_syn  ? synth_cfg :
                            hit_src  ? {29'h0000_0000, cur_src} : `CSCU_ZERO;
    wire        irq_any   = |(rdy_stat & int_en[`CSCU_B_IE_LSB + 3:`CSCU_B_IE_LSB]);

    // Synchroniser for the monitor input
    always_ff @(posedge clk) begin
        if (!nrst) begin
            fail_s1 <= 1'b0;
            fail_s2 <= 1'b0;
        end else begin
            fail_s1 <= crystal_fail;
            fail_s2 <= fail_s1;
        end
    end

    // Registers and state
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cfg        <= `CSCU_CFG_RST;
            ctl        <= `CSCU_CTL_RST;
            int_en     <= `CSCU_ZERO;
            synth_cfg  <= `CSCU_ZERO;
            stuck_flag <= 1'b0;
            synth_ref  <= 1'b1;
            cur_src    <= `CSCU_SRC_FAST;
            mode       <= CSCU_RUN;
        end else begin
            cfg        <= next_cfg;
            ctl        <= next_ctl;
            int_en     <= next_ien;
            synth_cfg  <= next_syn;
            stuck_flag <= next_stk;
            synth_ref  <= next_ref;
            cur_src    <= next_cur;
            mode       <= next_mode;
        end
    end

    // Bus answer
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= `CSCU_ZERO;
        end else begin
            wb_ack_o <= access;
            wb_dat_o <= access ? rd_word : wb_dat_o;
        end
    end

    // Registered outputs
    always_ff @(posedge clk) begin
        if (!nrst) begin
            crystal_osc_en      <= 1'b0;
            fast_rc_osc_en      <= 1'b1;
            slow_rc_osc_en      <= 1'b1;
            synth_en            <= 1'b0;
            synth_ref_fast_rc   <= 1'b1;
            crystal_clk_release <= 1'b0;
            system_clock_select <= `CSCU_SRC_FAST;
            wdt_clock_select    <= `CSCU_SRC_SLOW;
            feedback_div_value  <= `CSCU_FB_SIXTEEN;
            output_div_value    <= `CSCU_OD_ONE;
            clock_ready_irq     <= 1'b0;
            crystal_stuck_nmi   <= 1'b0;
        end else begin
            crystal_osc_en      <= en_eff[`CSCU_I_XTAL];
            fast_rc_osc_en      <= en_eff[`CSCU_I_FAST];
            slow_rc_osc_en      <= en_eff[`CSCU_I_SLOW];
            synth_en            <= en_eff[`CSCU_I_SYNTH];
            synth_ref_fast_rc   <= synth_ref;
            crystal_clk_release <= rdy[`CSCU_I_XTAL];
            system_clock_select <= cur_src;
            wdt_clock_select    <= `CSCU_SRC_SLOW;
            feedback_div_value  <= fb_val;
            output_div_value    <= od_val;
            clock_ready_irq     <= irq_any;
            crystal_stuck_nmi   <= stuck_flag & int_en[`CSCU_B_STUCK_IE];
        end
    end

    // Cycles the crystal timer has been enabled, saturating
    cscu_cnt_type xtal_on_cnt;
    always_ff @(posedge clk) begin
        if (!nrst || !tmr_en[`CSCU_I_XTAL]) begin
            xtal_on_cnt <= 12'h000;
        end else if (xtal_on_cnt != 12'hFFF) begin
            xtal_on_cnt <= xtal_on_cnt + 12'h001;
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_fail_to_fast;
        fail_evt |=> (cur_src == `CSCU_SRC_FAST) ##1 (system_clock_select == `CSCU_SRC_FAST);
    endproperty
    a_fail_to_fast: assert property (p_fail_to_fast) else $error("failure did not force fast RC");

    property p_fail_xtal_off;
        fail_evt |=> !ctl[`CSCU_B_XTAL] && stuck_flag;
    endproperty
    a_fail_xtal_off: assert property (p_fail_xtal_off) else $error("crystal not stopped on failure");

    property p_nmi;
        stuck_flag && int_en[`CSCU_B_STUCK_IE] |=> crystal_stuck_nmi;
    endproperty
    a_nmi: assert property (p_nmi) else $error("stuck interrupt missing");

    property p_syn_kill;
        syn_kill |=> !ctl[`CSCU_B_SYNTH];
    endproperty
    a_syn_kill: assert property (p_syn_kill) else $error("synthesiser kept on after failure");

    property p_release;
        $rose(crystal_clk_release) |-> $past(xtal_on_cnt) >= START_CYC[`CSCU_I_XTAL];
    endproperty
    a_release: assert property (p_release) else $error("crystal clock released early");

    property p_switch_wait;
        $changed(cur_src) && !$past(fail_evt) && !$past(wake_hit) |-> $past(tgt_rdy);
    endproperty
    a_switch_wait: assert property (p_switch_wait) else $error("switched to unready source");

    property p_wake;
        wake_hit && !fail_evt |=> cur_src == `CSCU_SRC_FAST && mode == CSCU_WAKE;
    endproperty
    a_wake: assert property (p_wake) else $error("wakeup not on fast RC");

    property p_wake_return;
        mode == CSCU_WAKE && !fail_evt && tgt_rdy |=> cur_src == $past(sw_sel) && mode == CSCU_RUN;
    endproperty
    a_wake_return: assert property (p_wake_return) else $error("wakeup did not return to source");

    property p_slow_on;
        $past(nrst) |-> slow_rc_osc_en && wdt_clock_select == `CSCU_SRC_SLOW;
    endproperty
    a_slow_on: assert property (p_slow_on) else $error("slow RC or watchdog source wrong");

    property p_irq;
        irq_any |=> clock_ready_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("ready interrupt missing");

    property p_ready_sticky;
        rdy_stat[`CSCU_I_XTAL] && !wclr[`CSCU_B_RDY_LSB + `CSCU_I_XTAL] |=> rdy_stat[`CSCU_I_XTAL];
    endproperty
    a_ready_sticky: assert property (p_ready_sticky) else $error("ready status lost without clear");

    property p_rdy_drop;
        !tmr_en[`CSCU_I_XTAL] |=> !rdy[`CSCU_I_XTAL] ##1 !crystal_clk_release;
    endproperty
    a_rdy_drop: assert property (p_rdy_drop) else $error("crystal ready kept while off");

    property p_fb16;
        synth_cfg[`CSCU_FB_MSB:0] == `CSCU_FB_ZERO |=> feedback_div_value == `CSCU_FB_SIXTEEN;
    endproperty
    a_fb16: assert property (p_fb16) else $error("feedback code zero not 16");
endmodule

// file: cscu_xtal_model.sv
// Crystal oscillator seen from the unit: reports a failure level on command.
// Assumes fail_cmd is driven by the bench on clk.
`timescale 1ns/1ps
module cscu_xtal_model (
    // Clock
    input  wire logic clk,
    // Control
    input  wire logic crystal_osc_en,
    input  wire logic fail_cmd,
    // Monitor level
    output logic      crystal_fail
);
    // Failure only shows while the crystal is powered
    always_ff @(posedge clk) begin
        crystal_fail <= fail_cmd & crystal_osc_en;
    end
endmodule

// file: clock_source_control_unit_tb.sv
// Self-checking bench of the clock source control unit.
// Assumes cscu_top with its package and the crystal model.
`timescale 1ns/1ps
module clock_source_control_unit_tb;
    import cscu_pkg::*;
    logic clk = 0, nrst = 0, cyc = 0, stb = 0, we = 0, wake = 0, fcmd = 0, cfail;
    logic [11:0] adr = 0;
    logic [3:0]  sel = 0;
    logic [31:0] wdat = 0, q;
    logic [31:0] rdat;
    logic ack, xen, fen, sen, pen, pref, rel, irq, nmi;
    cscu_src_type sys, wdt;
    logic [4:0]  fbv;
    logic [3:0]  odv, fc;
    logic [1:0]  oc;
    integer seed = 32'h2d55_94ac;
    int n_mismatch = 0, tests_run = 0;

    always #4 clk = ~clk;
    cscu_top i_dut (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .crystal_fail(cfail),
        .wake_req(wake), .crystal_osc_en(xen), .fast_rc_osc_en(fen), .slow_rc_osc_en(sen), .synth_en(pen),
        .synth_ref_fast_rc(pref), .crystal_clk_release(rel), .system_clock_select(sys),
        .wdt_clock_select(wdt), .feedback_div_value(fbv), .output_div_value(odv), .clock_ready_irq(irq),
        .crystal_stuck_nmi(nmi));
    cscu_xtal_model i_xtal (.clk(clk), .crystal_osc_en(xen), .fail_cmd(fcmd), .crystal_fail(cfail));

    function automatic logic [4:0] fb_exp(input logic [3:0] c);
        return (c == 4'h0) ? 5'h10 : {1'b0, c};
    endfunction
    function automatic logic [3:0] od_exp(input logic [1:0] c);
        return 4'h1 << c;
    endfunction

    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_mismatch++;
            end_sim;
        end
        r = rdat;
        cyc <= 0; stb <= 0; we <= 0;
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
    endtask

    initial begin
        wait_n(20000);
        n_mismatch++;
        end_sim;
    end

    initial begin
        wait_n(6);
        nrst <= 1;
        wb(0, 12'h004, 0, q);
        chk(q, 32'h0000_0803);
        wb(0, 12'h008, 0, q);
        chk(q, 32'h0000_0000);
        chk(sys, 3'h3);
        chk(wdt, 3'h7);
        chk(sen, 1'b1);
        wb(0, 12'h040, 0, q);
        chk(q, 32'h0000_0000);
        wait_n(210);
        wb(0, 12'h008, 0, q);
        chk(q, 32'h0000_0028);
        chk(irq, 1'b0);
        // Divider codes: corners then random
        for (int i = 0; i < 10; i++) begin
            fc = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : 4'($random(seed));
            oc = 2'(i);
            if (i > 3) oc = 2'($random(seed));
            wb(1, 12'h018, {26'h0, oc, fc}, q);
            wait_n(2);
            chk(fbv, fb_exp(fc));
            chk(odv, od_exp(oc));
        end
        // Crystal ready interrupt, switch target not yet ready
        wb(1, 12'h00C, 32'h0008_0000, q);
        wb(1, 12'h004, 32'h0000_0C02, q);
        wait_n(2);
        chk(xen, 1'b1);
        wait_n(100);
        chk(rel, 1'b0);
        chk(sys, 3'h3);
        for (int n = 0; n < 700 && rel !== 1'b1; n++) @(posedge clk);
        wait_n(4);
        chk(rel, 1'b1);
        chk(sys, 3'h2);
        chk(irq, 1'b1);
        wb(0, 12'h00C, 0, q);
        chk(q, 32'h0008_0038);
        wb(1, 12'h00C, 32'h0008_0038, q);
        wait_n(3);
        chk(irq, 1'b0);
        // Wakeup runs from fast RC for one cycle, then returns
        wb(1, 12'h004, 32'h0002_0C02, q);
        @(posedge clk) wake <= 1;
        @(posedge clk) wake <= 0;
        @(posedge clk);
        @(negedge clk);
        chk(sys, 3'h3);
        wait_n(4);
        chk(sys, 3'h2);
        // Crystal failure with monitor on
        wb(1, 12'h00C, 32'h0009_0000, q);
        wb(1, 12'h004, 32'h0003_0C02, q);
        @(posedge clk) fcmd <= 1;
        wait_n(8);
        chk(xen, 1'b0);
        chk(sys, 3'h3);
        chk(nmi, 1'b1);
        chk(rel, 1'b0);
        wb(0, 12'h004, 0, q);
        chk(q, 32'h0003_0803);
        wb(0, 12'h00C, 0, q);
        chk(q, 32'h0009_0001);
        // Synthesiser from fast RC, switch once locked
        wb(1, 12'h018, 32'h0000_0016, q);
        wb(1, 12'h00C, 32'h0005_0000, q);
        wb(1, 12'h004, 32'h0003_0A01, q);
        wait_n(2);
        chk(pen, 1'b1);
        chk(pref, 1'b1);
        chk(fen, 1'b1);
        chk(sys, 3'h3);
        chk(fbv, fb_exp(4'h6));
        chk(odv, od_exp(2'h1));
        q = 0;
        for (int k = 0; k < 80 && q[1] !== 1'b1; k++) begin
            wb(0, 12'h008, 0, q);
            wait_n(4);
        end
        chk(q, 32'h0000_002A);
        wait_n(4);
        chk(sys, 3'h1);
        chk(irq, 1'b1);
        end_sim;
    end
endmodule
